// ---- hdl/jfp_pkg.sv ----
package jfp_pkg;
	// Instruction register and opcodes.
	localparam int IR_W = 4;
	localparam logic [3:0] IR_CAPTURE = 4'h1;
	localparam logic [3:0] OP_CORE_RESET = 4'hC;
	localparam logic [3:0] OP_UNLOCK = 4'h4;
	localparam logic [3:0] OP_COMMAND = 4'h5;
	localparam logic [3:0] OP_PAGE_LOAD = 4'h6;
	localparam logic [3:0] OP_PAGE_READ = 4'h7;
	localparam logic [3:0] OP_BYPASS = 4'hF;
	// Data register widths and the unlock signature.
	localparam int EN_W = 16;
	localparam int CMD_W = 15;
	localparam logic [15:0] UNLOCK_SIG = 16'hA370;
	// Command field positions.
	localparam int DONE_BIT = 9;
	localparam int STROBE_BIT = 9;
	localparam int HIBYTE_BIT = 10;
	localparam int LATCH_BIT = 14;
	// Command prefixes.
	localparam logic [6:0] PFX_MODE = 7'h23;
	localparam logic [6:0] PFX_ADDR_EXT = 7'h0B;
	localparam logic [6:0] PFX_ADDR_HI = 7'h07;
	localparam logic [6:0] PFX_ADDR_LO = 7'h03;
	localparam logic [6:0] PFX_DATA_LO = 7'h13;
	localparam logic [6:0] PFX_DATA_HI = 7'h17;
	localparam logic [6:0] PFX_READ_LO = 7'h32;
	localparam logic [6:0] PFX_READ_HI = 7'h36;
	localparam logic [6:0] PFX_PAGE_WR = 7'h35;
	localparam logic [6:0] PFX_ERASE_WR = 7'h31;
	localparam logic [6:0] PFX_LATCH = 7'h77;
	// Mode operands of the mode prefix.
	localparam logic [7:0] OPD_ERASE = 8'h80;
	localparam logic [7:0] OPD_FL_WR = 8'h10;
	localparam logic [7:0] OPD_FL_RD = 8'h02;
	localparam logic [7:0] OPD_EE_WR = 8'h11;
	localparam logic [7:0] OPD_NOP = 8'h00;
	// Bus register map, status fields and reset values.
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_STATUS = 8'h04;
	localparam logic [7:0] ADR_ADDR = 8'h08;
	localparam logic [15:0] CTRL_RESET = 16'h0400;
	localparam int ST_PROG_EN = 0;
	localparam int ST_CORE_HOLD = 1;
	localparam int ST_CHAIN = 2;
	localparam int ST_BUSY = 3;
	localparam int ST_IR_LSB = 4;
	localparam int ST_MODE_LSB = 8;
	// Test access port states, one-hot.
	typedef enum logic [15:0] {
		TAP_TLR = 16'h0001, TAP_RTI = 16'h0002, TAP_SELDR = 16'h0004,
		TAP_CAPDR = 16'h0008, TAP_SHDR = 16'h0010, TAP_EX1DR = 16'h0020,
		TAP_PAUDR = 16'h0040, TAP_EX2DR = 16'h0080, TAP_UPDDR = 16'h0100,
		TAP_SELIR = 16'h0200, TAP_CAPIR = 16'h0400, TAP_SHIR = 16'h0800,
		TAP_EX1IR = 16'h1000, TAP_PAUIR = 16'h2000, TAP_EX2IR = 16'h4000,
		TAP_UPDIR = 16'h8000
	} jfp_tap_t;
	// Programming modes, one-hot.
	typedef enum logic [4:0] {
		MODE_NONE = 5'h01, MODE_ERASE = 5'h02, MODE_FL_WR = 5'h04,
		MODE_FL_RD = 5'h08, MODE_EE_WR = 5'h10
	} jfp_mode_t;
endpackage : jfp_pkg

// ---- hdl/jfp_pin_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Synchronised link pins and link clock edges.
interface jfp_pin_if;
	logic tckRise;
	logic tckFall;
	logic tms;
	logic tdi;
	modport src (output tckRise, output tckFall, output tms, output tdi);
	modport dst (input tckRise, input tckFall, input tms, input tdi);
endinterface : jfp_pin_if
`default_nettype wire

// ---- hdl/jfp_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module jfp_sync (
	input wire logic clk,
	input wire logic resetn,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	jfp_pin_if.src pins
);
	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic tckOld;
	} jfp_sync_t;

	jfp_sync_t r;
	jfp_sync_t n;

	// The first stage feeds only the second; edges are found past stage two.
	always_comb begin
		n = r;
		n.s1 = {tdi, tms, tck};
		n.s2 = r.s1;
		n.tckOld = r.s2[0];
	end

	// All pins reset low; no edge is seen during reset.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// Edge pulses last one system clock each.
	assign pins.tckRise = r.s2[0] && !r.tckOld;
	assign pins.tckFall = !r.s2[0] && r.tckOld;
	assign pins.tms = r.s2[1];
	assign pins.tdi = r.s2[2];
endmodule : jfp_sync
`default_nettype wire

// ---- hdl/jfp_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module jfp_top
	import jfp_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdoOeN,
	output logic coreHold,
	output logic [14:0] memCmd,
	output logic memExec,
	output logic [23:0] memAddr,
	input wire logic [15:0] memRdWord,
	input wire logic memBusy,
	output logic memBufWr,
	output logic [15:0] memBufData,
	output logic [1:0] memBufMask,
	output logic memErase,
	output logic memPageWr,
	output logic memEeWr,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o
);
	typedef struct packed {
		jfp_tap_t tap;
		logic [3:0] ir;
		logic [3:0] irSh;
		logic chain;
		logic [15:0] en;
		logic progEn;
		logic [14:0] cmd;
		logic byp;
		logic [14:0] memCmd;
		jfp_mode_t mode;
		logic [23:0] addr;
		logic [7:0] dataLo;
		logic [7:0] dataHi;
		logic [7:0] rdByte;
		logic hiNext;
		logic first;
		logic [15:0] holdCnt;
		logic coreHold;
		logic tdo;
		logic tdoOeN;
		logic memExec;
		logic memErase;
		logic memPageWr;
		logic memEeWr;
		logic memBufWr;
		logic [15:0] memBufData;
		logic [1:0] memBufMask;
		logic [15:0] ctrl;
		logic ack;
		logic [31:0] datO;
	} jfp_state_t;

	jfp_state_t r;
	jfp_state_t n;
	jfp_pin_if pins ();
	logic [31:0] stat;
	logic [6:0] pfx;
	logic [7:0] opd;

	jfp_sync u_sync (
		.clk(clk),
		.resetn(resetn),
		.tck(tck),
		.tms(tms),
		.tdi(tdi),
		.pins(pins)
	);

	// Standard TAP transitions on TMS.
	function automatic jfp_tap_t tapNext(input jfp_tap_t s, input logic m);
		case (s)
		TAP_TLR: tapNext = m ? TAP_TLR : TAP_RTI;
		TAP_RTI: tapNext = m ? TAP_SELDR : TAP_RTI;
		TAP_SELDR: tapNext = m ? TAP_SELIR : TAP_CAPDR;
		TAP_CAPDR: tapNext = m ? TAP_EX1DR : TAP_SHDR;
		TAP_SHDR: tapNext = m ? TAP_EX1DR : TAP_SHDR;
		TAP_EX1DR: tapNext = m ? TAP_UPDDR : TAP_PAUDR;
		TAP_PAUDR: tapNext = m ? TAP_EX2DR : TAP_PAUDR;
		TAP_EX2DR: tapNext = m ? TAP_UPDDR : TAP_SHDR;
		TAP_UPDDR: tapNext = m ? TAP_SELDR : TAP_RTI;
		TAP_SELIR: tapNext = m ? TAP_TLR : TAP_CAPIR;
		TAP_CAPIR: tapNext = m ? TAP_EX1IR : TAP_SHIR;
		TAP_SHIR: tapNext = m ? TAP_EX1IR : TAP_SHIR;
		TAP_EX1IR: tapNext = m ? TAP_UPDIR : TAP_PAUIR;
		TAP_PAUIR: tapNext = m ? TAP_EX2IR : TAP_PAUIR;
		TAP_EX2IR: tapNext = m ? TAP_UPDIR : TAP_SHIR;
		TAP_UPDIR: tapNext = m ? TAP_SELDR : TAP_RTI;
		default: tapNext = TAP_TLR;
		endcase
	endfunction : tapNext

	// One process computes the whole next state; pulses default low.
	always_comb begin
		n = r;
		pfx = r.cmd[14:8];
		opd = r.cmd[7:0];
		stat = 32'h0000_0000;
		stat[ST_PROG_EN] = r.progEn;
		stat[ST_CORE_HOLD] = r.coreHold;
		stat[ST_CHAIN] = r.chain;
		stat[ST_BUSY] = memBusy;
		stat[ST_IR_LSB +: 4] = r.ir;
		stat[ST_MODE_LSB +: 5] = r.mode;
		n.memExec = 1'b0;
		n.memErase = 1'b0;
		n.memPageWr = 1'b0;
		n.memEeWr = 1'b0;
		n.memBufWr = 1'b0;
		n.ack = 1'b0;
		// Bus slave answers one cycle after the strobe, ack drops after.
		if (cyc_i && stb_i && !r.ack) begin
			n.ack = 1'b1;
			case (adr_i)
			ADR_CTRL: begin
				n.datO = {16'h0000, r.ctrl};
				if (we_i && sel_i[0]) n.ctrl[7:0] = dat_i[7:0];
				if (we_i && sel_i[1]) n.ctrl[15:8] = dat_i[15:8];
			end
			ADR_STATUS: n.datO = stat;
			ADR_ADDR: n.datO = {8'h00, r.addr};
			default: n.datO = 32'h0000_0000;
			endcase
		end
		// Link logic advances only on a sampled rising edge of TCK.
		if (pins.tckRise) begin
			n.tap = tapNext(r.tap, pins.tms);
			case (r.tap)
			TAP_TLR: begin
				n.ir = OP_BYPASS;
				n.first = 1'b1;
			end
			TAP_RTI: begin
				if (r.ir == OP_COMMAND) n.memExec = 1'b1;
			end
			TAP_CAPIR: n.irSh = IR_CAPTURE;
			TAP_SHIR: n.irSh = {pins.tdi, r.irSh[3:1]};
			TAP_UPDIR: begin
				n.ir = r.irSh;
				n.hiNext = 1'b0;
				n.first = 1'b1;
			end
			TAP_CAPDR: begin
				if (r.ir == OP_COMMAND) begin
					n.cmd = '0;
					n.cmd[DONE_BIT] = !memBusy;
					n.cmd[7:0] = r.rdByte;
				end else if (r.ir == OP_PAGE_READ && r.progEn) begin
					// Byte choice alternates; address moves after high.
					n.cmd[7:0] = r.hiNext ? memRdWord[15:8]
						: memRdWord[7:0];
					n.hiNext = !r.hiNext;
					if (r.hiNext) n.addr = r.addr + 24'h00_0001;
				end else if (r.ir != OP_PAGE_LOAD && r.ir != OP_UNLOCK
					&& r.ir != OP_CORE_RESET) begin
					n.byp = 1'b0;
				end
			end
			TAP_SHDR: begin
				case (r.ir)
				OP_CORE_RESET: n.chain = pins.tdi;
				OP_UNLOCK: n.en = {pins.tdi, r.en[15:1]};
				OP_COMMAND: n.cmd = {pins.tdi, r.cmd[14:1]};
				OP_PAGE_LOAD, OP_PAGE_READ:
					n.cmd[7:0] = {pins.tdi, r.cmd[7:1]};
				default: n.byp = pins.tdi;
				endcase
			end
			TAP_UPDDR: begin
				if (r.ir == OP_UNLOCK) begin
					n.progEn = (r.en == UNLOCK_SIG);
				end else if (r.ir == OP_COMMAND && r.progEn) begin
					n.memCmd = r.cmd;
					case (pfx)
					PFX_MODE: begin
						// Unknown operands leave the mode alone.
						case (opd)
						OPD_ERASE: n.mode = MODE_ERASE;
						OPD_FL_WR: n.mode = MODE_FL_WR;
						OPD_FL_RD: n.mode = MODE_FL_RD;
						OPD_EE_WR: n.mode = MODE_EE_WR;
						OPD_NOP: n.mode = MODE_NONE;
						default: n.mode = r.mode;
						endcase
					end
					PFX_ADDR_EXT: n.addr[23:16] = opd;
					PFX_ADDR_HI: n.addr[15:8] = opd;
					PFX_ADDR_LO: n.addr[7:0] = opd;
					PFX_DATA_LO: n.dataLo = opd;
					PFX_DATA_HI: n.dataHi = opd;
					PFX_READ_LO, PFX_READ_HI: begin
						// Result byte is read now and shifted out next time.
						if (r.mode == MODE_FL_RD) begin
							n.rdByte = r.cmd[HIBYTE_BIT] ? memRdWord[15:8]
								: memRdWord[7:0];
						end
					end
					PFX_PAGE_WR: begin
						// A falling strobe bit starts the page write.
						if (r.mode == MODE_FL_WR && r.memCmd[STROBE_BIT])
							n.memPageWr = 1'b1;
					end
					PFX_ERASE_WR: begin
						if (r.memCmd[STROBE_BIT]) begin
							n.memErase = (r.mode == MODE_ERASE);
							n.memEeWr = (r.mode == MODE_EE_WR);
						end
					end
					PFX_LATCH: begin
						// A rising latch bit moves the data word to the buffer.
						if (!r.memCmd[LATCH_BIT] && (r.mode == MODE_FL_WR
							|| r.mode == MODE_EE_WR)) begin
							n.memBufWr = 1'b1;
							n.memBufData = {r.dataHi, r.dataLo};
							n.memBufMask = (r.mode == MODE_FL_WR) ? 2'h3 : 2'h1;
						end
					end
					default: n.mode = r.mode;
					endcase
				end else if (r.ir == OP_PAGE_LOAD && r.progEn) begin
					// Write goes out on the next clock, far inside 11 TCK.
					if (!r.hiNext && !r.first)
						n.addr = r.addr + 24'h00_0001;
					n.memBufWr = 1'b1;
					n.memBufData = {r.cmd[7:0], r.cmd[7:0]};
					n.memBufMask = r.hiNext ? 2'h2 : 2'h1;
					n.hiNext = !r.hiNext;
					n.first = 1'b0;
				end
			end
			default: n.tap = tapNext(r.tap, pins.tms);
			endcase
		end
		// TDO changes on the falling edge so the host samples it stable.
		if (pins.tckFall) begin
			n.tdoOeN = !(r.tap == TAP_SHDR || r.tap == TAP_SHIR);
			if (r.tap == TAP_SHIR) begin
				n.tdo = r.irSh[0];
			end else begin
				case (r.ir)
				OP_CORE_RESET: n.tdo = r.chain;
				OP_UNLOCK: n.tdo = r.en[0];
				OP_COMMAND, OP_PAGE_LOAD, OP_PAGE_READ:
					n.tdo = r.cmd[0];
				default: n.tdo = r.byp;
				endcase
			end
		end
		// Reset time-out starts when the chain clears; CTRL sets its length.
		if (r.chain && !n.chain) begin
			n.holdCnt = r.ctrl;
		end else if (r.holdCnt != 16'h0000) begin
			n.holdCnt = r.holdCnt - 16'h0001;
		end
		n.coreHold = n.chain || (n.holdCnt != 16'h0000);
	end

	// Reset leaves the TAP in Test-Logic-Reset and programming locked.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			r <= '0;
			r.tap <= TAP_TLR;
			r.ir <= OP_BYPASS;
			r.mode <= MODE_NONE;
			r.ctrl <= CTRL_RESET;
			r.tdoOeN <= 1'b1;
			r.first <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// Every output is a field of the registered state.
	assign tdo = r.tdo;
	assign tdoOeN = r.tdoOeN;
	assign coreHold = r.coreHold;
	assign memCmd = r.memCmd;
	assign memExec = r.memExec;
	assign memAddr = r.addr;
	assign memBufWr = r.memBufWr;
	assign memBufData = r.memBufData;
	assign memBufMask = r.memBufMask;
	assign memErase = r.memErase;
	assign memPageWr = r.memPageWr;
	assign memEeWr = r.memEeWr;
	assign dat_o = r.datO;
	assign ack_o = r.ack;

	// Checks on the link behaviour.
	logic rise;
	logic upd;
	assign rise = pins.tckRise;
	assign upd = pins.tckRise && r.tap == TAP_UPDDR;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	AST_IR_CAPTURE: assert property (rise && r.tap == TAP_CAPIR
		|=> r.irSh == IR_CAPTURE) else $error("IR capture value wrong");
	AST_RTI_CLOCK: assert property (rise && r.tap == TAP_RTI
		&& r.ir == OP_COMMAND |=> memExec ##1 !memExec)
		else $error("Idle cycle gave no single clock");
	AST_CHAIN_HOLD: assert property ($rose(r.chain) |-> coreHold)
		else $error("Core not held by reset chain");
	AST_TIMEOUT: assert property ($fell(r.chain) && r.ctrl > 16'h0001
		|-> coreHold [*2]) else $error("Reset time-out cut short");
	AST_UNLOCK: assert property (upd && r.ir == OP_UNLOCK
		|=> r.progEn == ($past(r.en) == UNLOCK_SIG))
		else $error("Unlock compare wrong");
	AST_CMD_APPLY: assert property (upd && r.ir == OP_COMMAND
		&& r.progEn |=> memCmd == $past(r.cmd))
		else $error("Command not applied at update");
	AST_RESULT: assert property (rise && r.tap == TAP_CAPDR
		&& r.ir == OP_COMMAND |=> r.cmd[DONE_BIT] == !$past(memBusy))
		else $error("Completion flag not captured");
	AST_PL_FIRST: assert property (upd && r.ir == OP_PAGE_LOAD
		&& r.progEn && r.first |=> memBufWr && memBufMask == 2'h1
		&& memAddr == $past(r.addr)) else $error("First load not low");
	AST_PR_INC: assert property (rise && r.tap == TAP_CAPDR
		&& r.ir == OP_PAGE_READ && r.progEn && r.hiNext
		|=> r.addr == $past(r.addr) + 24'h00_0001)
		else $error("Read address not advanced");
	AST_TDO_LSB: assert property (pins.tckFall && r.tap == TAP_SHDR
		&& r.ir == OP_COMMAND |=> tdo == $past(r.cmd[0]) && !tdoOeN)
		else $error("TDO not least significant bit");
	AST_UNKNOWN: assert property (upd && r.ir == OP_COMMAND
		&& r.progEn && pfx == PFX_MODE && opd == 8'h01
		|=> $stable(r.mode)) else $error("Unknown command changed mode");

	COV_UNLOCK: cover property (upd && r.ir == OP_UNLOCK
		##1 r.progEn);
	COV_PAGE_WR: cover property (memPageWr);
	COV_PAGE_LOAD: cover property (memBufWr && memBufMask == 2'h2);
	COV_READ_HI: cover property (rise && r.tap == TAP_CAPDR
		&& r.ir == OP_PAGE_READ && r.hiNext);
endmodule : jfp_top
`default_nettype wire

// ---- test/jfp_prog_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Behavioural link programmer; its clock rests low between frames.
module jfp_prog_model (
	input wire logic clk,
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	// Idle levels before the first frame.
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// One link period of 16 clk; tdo is taken just before the rise.
	task automatic tclk(input logic m, input logic d, output logic o);
		tms <= m;
		tdi <= d;
		repeat (8) @(posedge clk);
		o = tdo;
		tck <= 1'b1;
		repeat (8) @(posedge clk);
		tck <= 1'b0;
	endtask : tclk

	// Five ones reach Test-Logic-Reset from any state, then park in idle.
	task automatic reset_tap();
		logic o;
		repeat (5) tclk(1'b1, 1'b0, o);
		tclk(1'b0, 1'b0, o);
	endtask : reset_tap

	// Idle periods; each one clocks the applied command.
	task automatic idle(input int n);
		logic o;
		repeat (n) tclk(1'b0, 1'b0, o);
	endtask : idle

	// Scans one register from idle back to idle.
	task automatic scan(input logic ir, input logic [15:0] v, input int n,
		output logic [15:0] q);
		logic o;
		q = '0;
		tclk(1'b1, 1'b0, o);
		if (ir) begin
			tclk(1'b1, 1'b0, o);
		end
		tclk(1'b0, 1'b0, o);
		tclk(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++) begin
			tclk(i == n - 1, v[i], o);
			q[i] = o;
		end
		tclk(1'b1, 1'b0, o);
		tclk(1'b0, 1'b0, o);
	endtask : scan
endmodule : jfp_prog_model
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb
	import jfp_pkg::*;
;
	logic clk, resetn, tck, tms, tdi, tdo, tdoOeN, tdoLine, coreHold;
	logic memExec, memBusy, memBufWr, memErase, memPageWr, memEeWr;
	logic [14:0] memCmd;
	logic [23:0] memAddr, base;
	logic [15:0] memRdWord, memBufData, q, w;
	logic [1:0] memBufMask;
	logic cyc, stb, we, ackO;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] datI, datO, rd;
	logic [47:0] bufQ[$];
	logic [7:0] opds[4] = '{OPD_ERASE, OPD_FL_WR, OPD_EE_WR, OPD_FL_RD};
	jfp_mode_t modes[4] = '{MODE_ERASE, MODE_FL_WR, MODE_EE_WR, MODE_FL_RD};
	int failures = 0, num_checks = 0, cycles = 0, execCnt = 0, pwCnt = 0;
	int n, erCnt = 0, eeCnt = 0;

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// The test data line has a pull-up while the block releases it.
	assign tdoLine = tdoOeN ? 1'b1 : tdo;

	jfp_top jfp_top_inst (.clk(clk), .resetn(resetn), .tck(tck), .tms(tms),
		.tdi(tdi), .tdo(tdo), .tdoOeN(tdoOeN), .coreHold(coreHold),
		.memCmd(memCmd), .memExec(memExec), .memAddr(memAddr),
		.memRdWord(memRdWord), .memBusy(memBusy), .memBufWr(memBufWr),
		.memBufData(memBufData), .memBufMask(memBufMask),
		.memErase(memErase), .memPageWr(memPageWr), .memEeWr(memEeWr),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
		.dat_i(datI), .dat_o(datO), .ack_o(ackO));

	jfp_prog_model jfp_prog_model_inst (.clk(clk), .tck(tck), .tms(tms),
		.tdi(tdi), .tdo(tdoLine));

	// Flash content is a fixed function of the word address.
	function automatic logic [15:0] flash_word(input logic [23:0] a);
		return {~a[7:0], a[7:0] ^ 8'h5A};
	endfunction : flash_word

	always @(posedge clk) begin
		memRdWord <= flash_word(memAddr);
	end

	// Event monitors and the hang guard.
	always @(posedge clk) begin
		cycles++;
		if (memExec === 1'b1) execCnt++;
		if (memPageWr === 1'b1) pwCnt++;
		if (memErase === 1'b1) erCnt++;
		if (memEeWr === 1'b1) eeCnt++;
		if (memBufWr === 1'b1) bufQ.push_back({memAddr, 6'h00,
			memBufMask, memBufData});
		if (cycles == 40000) begin
			failures++;
			$display("FAIL at %0t: cycles %h expected below %h", $time,
				cycles, 40000);
			end_sim();
		end
	end

	task automatic end_sim();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Classic single cycle; the master waits for ack, which must come in fewer than 50 cycles.
	task automatic wb(input logic w1, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int k;
		k = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w1;
		adr <= a;
		datI <= d;
		do begin
			@(posedge clk);
			k++;
		end while (ackO !== 1'b1);
		r = datO;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		chk(48'(k < 50), 48'h1);
		@(posedge clk);
	endtask : wb

	task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		wb(1'b0, a, 32'h0, rd);
		chk(48'(rd & m), 48'(e));
	endtask : rdchk

	task automatic ir(input logic [3:0] op);
		jfp_prog_model_inst.scan(1'b1, {12'h000, op}, 4, q);
	endtask : ir

	task automatic dr(input logic [15:0] v, input int len);
		jfp_prog_model_inst.scan(1'b0, v, len, q);
	endtask : dr

	task automatic cmd(input logic [6:0] p, input logic [7:0] o);
		dr({1'b0, p, o}, 15);
	endtask : cmd

	initial begin
		resetn = 1'b0;
		{cyc, stb, we, memBusy} = 4'h0;
		adr = 8'h00;
		sel = 4'hF;
		datI = 32'h0;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		jfp_prog_model_inst.reset_tap();
		// Defaults, a short time-out written back, an unmapped read.
		rdchk(ADR_STATUS, 32'hFFFFFFFF, 32'h000001F0);
		rdchk(ADR_CTRL, 32'hFFFF, 32'h0400);
		wb(1'b1, ADR_CTRL, 32'h0100, rd);
		rdchk(ADR_CTRL, 32'hFFFF, 32'h0100);
		rdchk(8'h10, 32'hFFFFFFFF, 32'h0);
		$display("test registers done");
		// Hold the core first; the chain output acts at once.
		ir(OP_CORE_RESET);
		chk(48'(q[3:0]), 48'(IR_CAPTURE));
		dr(16'h0001, 1);
		chk(48'(coreHold), 48'h1);
		// A near-miss signature leaves commands locked out.
		ir(OP_UNLOCK);
		dr(16'hA371, 16);
		rdchk(ADR_STATUS, 32'h1, 32'h0);
		ir(OP_COMMAND);
		cmd(PFX_ADDR_LO, 8'h77);
		rdchk(ADR_ADDR, 32'hFFFFFF, 32'h0);
		ir(OP_UNLOCK);
		dr(16'hA370, 16);
		rdchk(ADR_STATUS, 32'h1, 32'h1);
		$display("test unlock done");
		ir(OP_COMMAND);
		for (int i = 0; i < 4; i++) begin
			cmd(PFX_MODE, opds[i]);
			rdchk(ADR_STATUS, 32'h1F00, {19'h0, modes[i], 8'h00});
		end
		cmd(PFX_ADDR_EXT, 8'h01);
		cmd(PFX_ADDR_HI, 8'h23);
		cmd(PFX_ADDR_LO, 8'h45);
		base = 24'h012345;
		rdchk(ADR_ADDR, 32'hFFFFFF, 32'h012345);
		cmd(7'h7C, 8'h55);
		cmd(PFX_MODE, 8'h01);
		chk(48'(memCmd), 48'({PFX_MODE, 8'h01}));
		rdchk(ADR_STATUS, 32'h1F00, {19'h0, MODE_FL_RD, 8'h00});
		rdchk(ADR_ADDR, 32'hFFFFFF, 32'h012345);
		$display("test commands done");
		// Word read returns low then high; bit nine reports completion.
		w = flash_word(base);
		cmd(PFX_READ_LO, 8'h00);
		cmd(PFX_READ_HI, 8'h00);
		chk(48'(q[7:0]), 48'(w[7:0]));
		cmd(7'h37, 8'h00);
		chk(48'(q[7:0]), 48'(w[15:8]));
		chk(48'(q[DONE_BIT]), 48'h1);
		memBusy <= 1'b1;
		cmd(7'h37, 8'h00);
		chk(48'(q[DONE_BIT]), 48'h0);
		memBusy <= 1'b0;
		n = 0;
		do begin
			cmd(7'h37, 8'h00);
			n++;
		end while (q[DONE_BIT] !== 1'b1 && n < 4);
		chk(48'(q[DONE_BIT]), 48'h1);
		execCnt = 0;
		jfp_prog_model_inst.idle(5);
		chk(48'(execCnt), 48'h5);
		$display("test read done");
		// Page read walks low, high, then the next word's low byte.
		ir(OP_PAGE_READ);
		dr(16'h0, 8);
		chk(48'(q[7:0]), 48'(w[7:0]));
		dr(16'h0, 8);
		chk(48'(q[7:0]), 48'(w[15:8]));
		w = flash_word(base + 24'h1);
		dr(16'h0, 8);
		chk(48'(q[7:0]), 48'(w[7:0]));
		rdchk(ADR_ADDR, 32'hFFFFFF, 32'(base + 24'h1));
		$display("test page read done");
		// Page load: low byte at the preset word, high, then pre-increment.
		ir(OP_COMMAND);
		cmd(PFX_MODE, OPD_FL_WR);
		cmd(PFX_ADDR_LO, 8'h45);
		ir(OP_PAGE_LOAD);
		bufQ.delete();
		dr(16'h0011, 8);
		chk(48'(bufQ.size()), 48'h1);
		dr(16'h0022, 8);
		dr(16'h0033, 8);
		chk(48'(bufQ.size()), 48'h3);
		chk(bufQ[0], {base, 6'h0, 2'b01, 16'h1111});
		chk(bufQ[1], {base, 6'h0, 2'b10, 16'h2222});
		chk(bufQ[2], {base + 24'h1, 6'h0, 2'b01, 16'h3333});
		// Page write strobe bracketed by idle commands.
		ir(OP_COMMAND);
		pwCnt = 0;
		cmd(7'h37, 8'h00);
		cmd(PFX_PAGE_WR, 8'h00);
		cmd(7'h37, 8'h00);
		chk(48'(pwCnt), 48'h1);
		// A rising latch bit moves the loaded word with both bytes enabled.
		cmd(PFX_DATA_LO, 8'hA5);
		cmd(PFX_DATA_HI, 8'h5A);
		bufQ.delete();
		cmd(PFX_LATCH, 8'h00);
		cmd(7'h37, 8'h00);
		chk(48'(bufQ.size()), 48'h1);
		chk(bufQ[0], {base + 24'h1, 6'h0, 2'b11, 16'h5AA5});
		// Erase and EEPROM strobes each fire only in their own mode.
		cmd(PFX_MODE, OPD_ERASE);
		cmd(PFX_ERASE_WR, OPD_ERASE);
		cmd(7'h33, OPD_ERASE);
		chk(48'(erCnt), 48'h1);
		chk(48'(eeCnt), 48'h0);
		cmd(PFX_MODE, OPD_EE_WR);
		cmd(7'h33, 8'h00);
		cmd(PFX_ERASE_WR, 8'h00);
		cmd(7'h33, 8'h00);
		chk(48'(eeCnt), 48'h1);
		chk(48'(erCnt), 48'h1);
		$display("test page load done");
		// Leave: clear the signature, release the core after its time-out.
		cmd(PFX_MODE, OPD_NOP);
		ir(OP_UNLOCK);
		dr(16'h0000, 16);
		rdchk(ADR_STATUS, 32'h1, 32'h0);
		ir(OP_CORE_RESET);
		dr(16'h0000, 1);
		chk(48'(coreHold), 48'h1);
		repeat (300) @(posedge clk);
		chk(48'(coreHold), 48'h0);
		$display("test leave done");
		end_sim();
	end
endmodule : tb
`default_nettype wire
